//--- rtl/isf_pkg.sv
/*
 * Constants, mode decodes and filters for the two-wire slave with
 * clock stretching and firmware master support.
 * Assumes a single system clock plus a free-running link oversample clock.
 */
package isf_pkg;

	// ****************************************************
	// port mode codes
	// ****************************************************
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_FWM_IDLE = 4'hB;
	localparam logic [3:0] MODE_SLV7_SP = 4'hE;
	localparam logic [3:0] MODE_SLV10_SP = 4'hF;

	// ****************************************************
	// link to system event kinds
	// ****************************************************
	localparam logic [1:0] KIND_ADDR = 2'h0;
	localparam logic [1:0] KIND_ADDR10 = 2'h1;
	localparam logic [1:0] KIND_RXDATA = 2'h2;
	localparam logic [1:0] KIND_TXDONE = 2'h3;

	// ****************************************************
	// counts and reset values
	// ****************************************************
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [1:0] PH_ADDR1 = 2'h0;
	localparam logic [1:0] PH_ADDR2 = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;
	localparam logic REL_RST = 1'h1;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] BUF_RST = 8'h00;
	localparam int FIFO_WIDTH_DEF = 8;
	localparam int FIFO_DEPTH_DEF = 8;

	// ****************************************************
	// helpers
	// ****************************************************
	// filtered level follows once stages two and three agree
	function automatic logic isf_filt(input logic [2:0] s, input logic f);
		return (s[1] == s[2]) ? s[2] : f;
	endfunction

	function automatic logic isf_slave_on(input logic [3:0] m);
		return (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7_SP) ||
			(m == MODE_SLV10_SP);
	endfunction

	function automatic logic isf_ten_bit(input logic [3:0] m);
		return (m == MODE_SLV10) || (m == MODE_SLV10_SP);
	endfunction

	function automatic logic isf_sp_irq(input logic [3:0] m);
		return (m == MODE_SLV7_SP) || (m == MODE_SLV10_SP) || (m == MODE_FWM_IDLE);
	endfunction

endpackage

//--- rtl/isf_fifo.sv
/*
 * Shift-register FIFO; head word always sits in the first flop.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module isf_fifo import isf_pkg::*; #(
	parameter int WIDTH = FIFO_WIDTH_DEF,
	parameter int DEPTH = FIFO_DEPTH_DEF
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("isf_fifo: DEPTH must be at least 2 and WIDTH at least 1");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0] cnt;
		logic room;
		logic nonempty;
	} isf_fifo_s;

	isf_fifo_s q_r, q_nxt;
	logic push, pop;

	// ****************************************************
	// handshakes
	// ****************************************************
	assign push = in_valid && q_r.room;
	assign pop = out_ready && q_r.nonempty;
	assign in_ready = q_r.room;
	assign out_valid = q_r.nonempty;
	assign out_data = q_r.mem[0];

	// next state: shift on pop, write behind the last word on push
	always_comb begin
		q_nxt = q_r;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				q_nxt.mem[i] = q_r.mem[i+1];
			end
		end
		if (push) begin
			q_nxt.mem[pop ? q_r.cnt - 1'b1 : q_r.cnt] = in_data;
		end
		if (push && !pop) begin
			q_nxt.cnt = q_r.cnt + 1'b1;
		end else if (pop && !push) begin
			q_nxt.cnt = q_r.cnt - 1'b1;
		end
		q_nxt.room = q_nxt.cnt != CW'(DEPTH);
		q_nxt.nonempty = q_nxt.cnt != '0;
		if (!resetn) begin
			q_nxt.cnt = '0;
			q_nxt.room = 1'b1;
			q_nxt.nonempty = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		q_r <= q_nxt;
	end
endmodule
`default_nettype wire

//--- rtl/isf_core.sv
/*
 * Two-wire slave with hardware clock stretching, start/stop tracking
 * and firmware master pin control. Bus logic runs on link_clk, which
 * oversamples the pins; software side runs on clock.
 * Assumes open-drain pads resolved outside, mode field quasi-static,
 * address and transmit byte written before the clock is released.
 */
`timescale 1ns/1ps
`default_nettype none
module isf_core import isf_pkg::*; #(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// system clock and reset
	input wire logic clock,
	input wire logic resetn,
	// link oversample clock
	input wire logic link_clk,
	// bus clock pin
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	// bus data pin
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// control
	input wire logic serial_port_enable,
	input wire logic [3:0] port_mode_field,
	input wire logic pin_direction_bit_scl,
	input wire logic pin_direction_bit_sda,
	input wire logic clock_release_set,
	input wire logic irq_clear,
	// slave address and transmit byte writes
	input wire logic addr_wr,
	input wire logic [7:0] addr_wdata,
	input wire logic buf_wr,
	input wire logic [7:0] buf_wdata,
	// status
	output logic serial_port_irq_flag,
	output logic address_update_flag,
	output logic clock_release_bit,
	output logic start_seen,
	output logic stop_seen,
	output logic read_not_write,
	output logic [7:0] slave_address_reg,
	// received bytes
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data
);
	// ****************************************************
	// link domain state
	// ****************************************************
	typedef enum logic [2:0] {LK_IDLE, LK_RX, LK_ACK, LK_TX, LK_TXACK, LK_WAIT} isf_lk_e;

	typedef struct packed {
		logic [2:0] rst_s, scl_s, sda_s, en_s, dc_s, dd_s, ack_s;
		logic rst_f, scl_f, sda_f, en_f, dc_f, dd_f, ack_f;
	} isf_lksy_s;

	typedef struct packed {
		isf_lk_e st;
		logic [7:0] sh;
		logic [3:0] bcnt;
		logic [1:0] phase;
		logic rd, nack, drv, hold, req, st_t, sp_t;
		logic [7:0] pdata;
		logic [1:0] pkind;
		logic scl_oe, sda_oe, scl_o, sda_o;
	} isf_lkst_s;

	typedef struct packed {
		isf_lksy_s y;
		isf_lkst_s s;
	} isf_lk_s;

	// ****************************************************
	// system domain state
	// ****************************************************
	typedef struct packed {
		logic [2:0] req_s, st_s, sp_s;
		logic req_f, st_f, sp_f;
	} isf_sysy_s;

	typedef struct packed {
		logic rel, upd, irq, sseen, pseen, ack, taken, push, rd;
		logic [7:0] addr, txb, pdat;
	} isf_syst_s;

	typedef struct packed {
		isf_sysy_s y;
		isf_syst_s s;
	} isf_sy_s;

	isf_lk_s lk_r, lk_nxt;
	isf_sy_s sy_r, sy_nxt;
	logic fifo_in_ready;
	logic lk_fall_a, lk_start_a;
	logic sy_start_a, sy_stop_a, sy_take_a;

	// ****************************************************
	// link domain: pin filter, bus sequencer, pin drive
	// ****************************************************
	always_comb begin
		logic rise, fall, start_c, stop_c, match, hold_stop;
		rise = 1'b0;
		fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		match = 1'b0;
		hold_stop = 1'b0;
		lk_nxt = lk_r;
		// three-stage synchronisers
		lk_nxt.y.rst_s = {lk_r.y.rst_s[1:0], resetn};
		lk_nxt.y.scl_s = {lk_r.y.scl_s[1:0], scl_i};
		lk_nxt.y.sda_s = {lk_r.y.sda_s[1:0], sda_i};
		lk_nxt.y.en_s = {lk_r.y.en_s[1:0], serial_port_enable};
		lk_nxt.y.dc_s = {lk_r.y.dc_s[1:0], pin_direction_bit_scl};
		lk_nxt.y.dd_s = {lk_r.y.dd_s[1:0], pin_direction_bit_sda};
		lk_nxt.y.ack_s = {lk_r.y.ack_s[1:0], sy_r.s.ack};
		lk_nxt.y.rst_f = isf_filt(lk_r.y.rst_s, lk_r.y.rst_f);
		lk_nxt.y.scl_f = isf_filt(lk_r.y.scl_s, lk_r.y.scl_f);
		lk_nxt.y.sda_f = isf_filt(lk_r.y.sda_s, lk_r.y.sda_f);
		lk_nxt.y.en_f = isf_filt(lk_r.y.en_s, lk_r.y.en_f);
		lk_nxt.y.dc_f = isf_filt(lk_r.y.dc_s, lk_r.y.dc_f);
		lk_nxt.y.dd_f = isf_filt(lk_r.y.dd_s, lk_r.y.dd_f);
		lk_nxt.y.ack_f = isf_filt(lk_r.y.ack_s, lk_r.y.ack_f);
		// bus edges and conditions
		rise = lk_nxt.y.scl_f && !lk_r.y.scl_f;
		fall = !lk_nxt.y.scl_f && lk_r.y.scl_f;
		start_c = lk_r.y.scl_f && lk_nxt.y.scl_f && lk_r.y.sda_f && !lk_nxt.y.sda_f;
		stop_c = lk_r.y.scl_f && lk_nxt.y.scl_f && !lk_r.y.sda_f && lk_nxt.y.sda_f;
		// start/stop toggles for the system side
		if (start_c) begin
			lk_nxt.s.st_t = !lk_r.s.st_t;
		end
		if (stop_c) begin
			lk_nxt.s.sp_t = !lk_r.s.sp_t;
		end
		unique case (lk_r.s.st)
			LK_IDLE: begin
				lk_nxt.s.drv = 1'b0;
			end
			// shift in eight bits on rising edges
			LK_RX: begin
				if (rise) begin
					lk_nxt.s.sh = {lk_r.s.sh[6:0], lk_nxt.y.sda_f};
					lk_nxt.s.bcnt = lk_r.s.bcnt + 1'b1;
				end
				if (fall && lk_r.s.bcnt == BIT_LAST) begin
					unique case (lk_r.s.phase)
						PH_ADDR1: match = lk_r.s.sh[7:1] == sy_r.s.addr[7:1];
						PH_ADDR2: match = lk_r.s.sh == sy_r.s.addr;
						default: match = 1'b1;
					endcase
					if (lk_r.s.phase == PH_ADDR1) begin
						lk_nxt.s.rd = lk_r.s.sh[0];
					end
					lk_nxt.s.drv = match;
					lk_nxt.s.st = match ? LK_ACK : LK_IDLE;
				end
			end
			// acknowledge through the ninth clock, then hand over
			LK_ACK: begin
				if (fall) begin
					lk_nxt.s.drv = 1'b0;
					lk_nxt.s.req = !lk_r.s.req;
					lk_nxt.s.pdata = lk_r.s.sh;
					if (lk_r.s.phase == PH_DATA) begin
						lk_nxt.s.pkind = KIND_RXDATA;
					end else if (isf_ten_bit(port_mode_field)) begin
						lk_nxt.s.pkind = KIND_ADDR10;
					end else begin
						lk_nxt.s.pkind = KIND_ADDR;
					end
					lk_nxt.s.hold = 1'b1;
					lk_nxt.s.st = LK_WAIT;
				end
			end
			// shift out on falling edges
			LK_TX: begin
				if (fall) begin
					if (lk_r.s.bcnt == BIT_LAST) begin
						lk_nxt.s.drv = 1'b0;
						lk_nxt.s.st = LK_TXACK;
					end else begin
						lk_nxt.s.sh = {lk_r.s.sh[6:0], 1'b0};
						lk_nxt.s.drv = !lk_r.s.sh[6];
						lk_nxt.s.bcnt = lk_r.s.bcnt + 1'b1;
					end
				end
			end
			// read the master's acknowledge
			LK_TXACK: begin
				if (rise) begin
					lk_nxt.s.nack = lk_nxt.y.sda_f;
				end
				if (fall) begin
					lk_nxt.s.req = !lk_r.s.req;
					lk_nxt.s.pdata = {7'h00, lk_r.s.nack};
					lk_nxt.s.pkind = KIND_TXDONE;
					lk_nxt.s.hold = !lk_r.s.nack;
					lk_nxt.s.st = LK_WAIT;
				end
			end
			// clock held low, except after a master nack, until the system side answers
			LK_WAIT: begin
				if (lk_r.y.ack_f == lk_r.s.req) begin
					lk_nxt.s.hold = 1'b0;
					lk_nxt.s.bcnt = 4'h0;
					lk_nxt.s.st = LK_RX;
					if (lk_r.s.pkind == KIND_TXDONE && lk_r.s.nack) begin
						lk_nxt.s.st = LK_IDLE;
					end else if (lk_r.s.phase == PH_ADDR1 && isf_ten_bit(port_mode_field)
						&& !lk_r.s.rd) begin
						lk_nxt.s.phase = PH_ADDR2;
					end else begin
						lk_nxt.s.phase = PH_DATA;
						if (lk_r.s.rd) begin
							lk_nxt.s.sh = sy_r.s.txb;
							lk_nxt.s.drv = !sy_r.s.txb[7];
							lk_nxt.s.bcnt = 4'h1;
							lk_nxt.s.st = LK_TX;
						end
					end
				end
			end
			default: lk_nxt.s.st = LK_IDLE;
		endcase
		// start restarts and stop idles the sequencer unless stretching
		hold_stop = lk_r.s.st == LK_WAIT && lk_r.s.hold;
		if (start_c && !hold_stop) begin
			lk_nxt.s.st = LK_RX;
			lk_nxt.s.bcnt = 4'h0;
			lk_nxt.s.phase = PH_ADDR1;
			lk_nxt.s.rd = 1'b0;
			lk_nxt.s.drv = 1'b0;
			lk_nxt.s.hold = 1'b0;
		end else if (stop_c && !hold_stop) begin
			lk_nxt.s.st = LK_IDLE;
			lk_nxt.s.drv = 1'b0;
			lk_nxt.s.hold = 1'b0;
		end
		if (!lk_r.y.en_f || !isf_slave_on(port_mode_field)) begin
			if (lk_nxt.s.st != LK_WAIT) begin
				lk_nxt.s.st = LK_IDLE;
			end
			lk_nxt.s.drv = 1'b0;
			lk_nxt.s.hold = 1'b0;
		end
		// open-drain drive: output level is always low
		lk_nxt.s.scl_o = 1'b0;
		lk_nxt.s.sda_o = 1'b0;
		lk_nxt.s.scl_oe = lk_nxt.s.hold || !lk_r.y.dc_f;
		lk_nxt.s.sda_oe = lk_nxt.s.drv || !lk_r.y.dd_f;
		if (!lk_r.y.rst_f) begin
			lk_nxt.s = '0;
		end
	end

	assign lk_fall_a = !lk_nxt.y.scl_f && lk_r.y.scl_f;
	assign lk_start_a = lk_r.y.scl_f && lk_r.y.sda_f && !lk_nxt.y.sda_f && lk_nxt.y.scl_f;

	// link state register
	always_ff @(posedge link_clk) begin
		lk_r <= lk_nxt;
	end

	// ****************************************************
	// system domain: flags, release bit, handshake, fifo feed
	// ****************************************************
	always_comb begin
		logic pending;
		pending = 1'b0;
		sy_nxt = sy_r;
		sy_nxt.y.req_s = {sy_r.y.req_s[1:0], lk_r.s.req};
		sy_nxt.y.st_s = {sy_r.y.st_s[1:0], lk_r.s.st_t};
		sy_nxt.y.sp_s = {sy_r.y.sp_s[1:0], lk_r.s.sp_t};
		sy_nxt.y.req_f = isf_filt(sy_r.y.req_s, sy_r.y.req_f);
		sy_nxt.y.st_f = isf_filt(sy_r.y.st_s, sy_r.y.st_f);
		sy_nxt.y.sp_f = isf_filt(sy_r.y.sp_s, sy_r.y.sp_f);
		// software writes; hardware sets below win over clears
		if (irq_clear) begin
			sy_nxt.s.irq = 1'b0;
		end
		if (clock_release_set) begin
			sy_nxt.s.rel = 1'b1;
		end
		if (addr_wr) begin
			sy_nxt.s.addr = addr_wdata;
			sy_nxt.s.upd = 1'b0;
		end
		if (buf_wr) begin
			sy_nxt.s.txb = buf_wdata;
		end
		// start/stop status and interrupts
		if (serial_port_enable && sy_start_a) begin
			sy_nxt.s.sseen = 1'b1;
			sy_nxt.s.pseen = 1'b0;
			sy_nxt.s.irq = sy_nxt.s.irq || isf_sp_irq(port_mode_field);
		end
		if (serial_port_enable && sy_stop_a) begin
			sy_nxt.s.pseen = 1'b1;
			sy_nxt.s.sseen = 1'b0;
			sy_nxt.s.irq = sy_nxt.s.irq || isf_sp_irq(port_mode_field);
		end
		if (!serial_port_enable) begin
			sy_nxt.s.sseen = 1'b0;
			sy_nxt.s.pseen = 1'b0;
		end
		// take a new handover from the link side
		pending = sy_r.y.req_f != sy_r.s.ack;
		if (sy_take_a) begin
			sy_nxt.s.taken = 1'b1;
			sy_nxt.s.irq = 1'b1;
			unique case (lk_r.s.pkind)
				KIND_ADDR: begin
					sy_nxt.s.rd = lk_r.s.pdata[0];
					sy_nxt.s.rel = !lk_r.s.pdata[0] && sy_nxt.s.rel;
				end
				KIND_ADDR10: begin
					sy_nxt.s.upd = 1'b1;
					sy_nxt.s.rd = (lk_r.s.phase == PH_ADDR1) ? lk_r.s.pdata[0] : sy_r.s.rd;
					sy_nxt.s.rel = !(lk_r.s.pdata[0] && lk_r.s.phase == PH_ADDR1)
						&& sy_nxt.s.rel;
				end
				KIND_RXDATA: begin
					sy_nxt.s.push = 1'b1;
					sy_nxt.s.pdat = lk_r.s.pdata;
				end
				KIND_TXDONE: begin
					sy_nxt.s.rel = lk_r.s.pdata[0] && sy_nxt.s.rel;
				end
			endcase
		end
		if (sy_r.s.push && fifo_in_ready) begin
			sy_nxt.s.push = 1'b0;
		end
		// answer once released, address updated and byte stored
		if (pending && sy_r.s.taken && sy_r.s.rel && !sy_r.s.upd && !sy_r.s.push) begin
			sy_nxt.s.ack = !sy_r.s.ack;
			sy_nxt.s.taken = 1'b0;
		end
		if (!resetn) begin
			sy_nxt.s = '0;
			sy_nxt.s.rel = REL_RST;
			sy_nxt.s.addr = ADDR_RST;
			sy_nxt.s.txb = BUF_RST;
		end
	end

	assign sy_start_a = sy_nxt.y.st_f != sy_r.y.st_f;
	assign sy_stop_a = sy_nxt.y.sp_f != sy_r.y.sp_f;
	assign sy_take_a = (sy_r.y.req_f != sy_r.s.ack) && !sy_r.s.taken;

	// system state register
	always_ff @(posedge clock) begin
		sy_r <= sy_nxt;
	end

	// ****************************************************
	// received byte buffer
	// ****************************************************
	isf_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(sy_r.s.push),
		.in_ready(fifo_in_ready),
		.in_data(sy_r.s.pdat),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// ****************************************************
	// outputs
	// ****************************************************
	assign scl_o = lk_r.s.scl_o;
	assign scl_oe = lk_r.s.scl_oe;
	assign sda_o = lk_r.s.sda_o;
	assign sda_oe = lk_r.s.sda_oe;
	assign serial_port_irq_flag = sy_r.s.irq;
	assign address_update_flag = sy_r.s.upd;
	assign clock_release_bit = sy_r.s.rel;
	assign start_seen = sy_r.s.sseen;
	assign stop_seen = sy_r.s.pseen;
	assign read_not_write = sy_r.s.rd;
	assign slave_address_reg = sy_r.s.addr;

	// ****************************************************
	// assertions
	// ****************************************************
	property p_sys_hold(logic c);
		@(posedge clock) disable iff (!resetn) c |=> $stable(sy_r.s.ack);
	endproperty
	AST_UPD_STRETCH: assert property (p_sys_hold(sy_r.s.upd))
		else $error("answer given while address update pending");
	AST_REL_HOLD: assert property (p_sys_hold(!sy_r.s.rel))
		else $error("answer given while clock release bit clear");
	AST_LINK_HOLD: assert property (@(posedge link_clk) disable iff (!lk_r.y.rst_f)
		lk_r.s.st == LK_WAIT && lk_r.s.hold |-> lk_r.s.scl_oe)
		else $error("clock not held low while waiting");
	AST_UPD_WITH_IRQ: assert property (@(posedge clock) disable iff (!resetn)
		$rose(sy_r.s.upd) |-> sy_r.s.irq)
		else $error("address update flag without irq flag");
	AST_EN_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
		!serial_port_enable |=> !sy_r.s.sseen && !sy_r.s.pseen)
		else $error("start/stop seen not cleared when disabled");
	AST_START_SEEN: assert property (@(posedge clock) disable iff (!resetn)
		serial_port_enable && sy_start_a && !sy_stop_a |=> sy_r.s.sseen && !sy_r.s.pseen)
		else $error("start condition not recorded");
	AST_DIR_DRIVE: assert property (@(posedge link_clk) disable iff (!lk_r.y.rst_f)
		!lk_r.y.dd_f |=> lk_r.s.sda_oe && !lk_r.s.sda_o)
		else $error("data pin not driven low for output direction");
	AST_BYTE_IRQ: assert property (@(posedge clock) disable iff (!resetn)
		sy_take_a |=> sy_r.s.irq)
		else $error("byte event did not raise irq flag");
	AST_STOP_IRQ: assert property (@(posedge clock) disable iff (!resetn)
		serial_port_enable && sy_stop_a && isf_sp_irq(port_mode_field) |=> sy_r.s.irq)
		else $error("stop condition did not raise irq flag");
	AST_ACK_PULSE: assert property (@(posedge link_clk) disable iff (!lk_r.y.rst_f)
		lk_r.s.st == LK_ACK |-> lk_r.s.sda_oe)
		else $error("acknowledge not driven");
	AST_IRQ_STICKY: assert property (@(posedge clock) disable iff (!resetn)
		sy_r.s.irq && !irq_clear |=> sy_r.s.irq)
		else $error("irq flag dropped without clear");

	COV_START: cover property (@(posedge link_clk) disable iff (!lk_r.y.rst_f) lk_start_a);
	COV_UPD: cover property (@(posedge clock) disable iff (!resetn) $rose(sy_r.s.upd));
	COV_TX: cover property (@(posedge link_clk) disable iff (!lk_r.y.rst_f)
		lk_r.s.st == LK_TX && lk_fall_a);
	COV_FULL: cover property (@(posedge clock) disable iff (!resetn)
		sy_r.s.push && !fifo_in_ready);
endmodule
`default_nettype wire

//--- verif/isf_bus_master.sv
/*
 * Behavioural two-wire bus master for the bench: start, stop, bytes.
 * Assumes the bench resolves both lines with pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
module isf_bus_master (
	// resolved line levels
	input wire logic scl,
	input wire logic sda,
	// pull-down drives
	output logic scl_dn,
	output logic sda_dn
);
	localparam int HALF = 100;
	int n;
	logic lost;
	initial begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
		lost = 1'b0;
	end
	// release clock, wait out a stretch of up to 3000 polls of 10 ns
	task automatic clk_hi();
		scl_dn = 1'b0;
		n = 0;
		while (!scl && n < 3000) begin
			#10;
			n++;
		end
		#HALF;
	endtask
	// one bit, data changed in low phase
	task automatic bit_io(input logic b, output logic r);
		#20;
		sda_dn = !b;
		#HALF;
		clk_hi();
		r = sda;
		scl_dn = 1'b1;
	endtask
	// claim an idle bus
	task automatic start();
		lost = 1'b0;
		sda_dn = 1'b1;
		#HALF;
		scl_dn = 1'b1;
	endtask
	task automatic stop();
		#20;
		sda_dn = 1'b1;
		#HALF;
		clk_hi();
		sda_dn = 1'b0;
		#HALF;
	endtask
	// byte msb first, ack returned; gives up on lost arbitration
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		r = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			if (!lost) begin
				bit_io(d[i], r);
				lost = d[i] && !r;
			end
		end
		if (lost) begin
			sda_dn = 1'b0;
			scl_dn = 1'b0;
		end else begin
			bit_io(1'b1, r);
		end
		ack = !r && !lost;
	endtask
endmodule
`default_nettype wire

//--- verif/isf_core_tb_top.sv
/*
 * Bench for isf_core: software strobes plus a bus master model.
 * Assumes pull-ups on both bus lines.
 */
`timescale 1ns/1ps
`default_nettype none
module isf_core_tb_top;
	import isf_pkg::*;
	logic clock, resetn, link_clk, scl, sda, scl_o, sda_o, scl_oe, sda_oe;
	logic en, dir_scl, dir_sda, crs, irqc, addr_wr, buf_wr, rx_ready;
	logic [3:0] mode;
	logic [7:0] wdata, sar, rx_data;
	logic irq, upd, rel, ss, ps, rnw, rx_valid, bm_scl, bm_sda, ack;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	// ****************************************************
	// clocks, bus wiring, instances
	// ****************************************************
	initial begin
		clock = 1'b0;
		forever #2 clock = !clock;
	end
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = !link_clk;
	end
	// pull-ups on both lines
	assign scl = !(scl_oe | bm_scl);
	assign sda = !(sda_oe | bm_sda);
	isf_bus_master bm (.scl(scl), .sda(sda), .scl_dn(bm_scl), .sda_dn(bm_sda));
	isf_core #(.FIFO_DEPTH(8)) DUT (.clock(clock), .resetn(resetn), .link_clk(link_clk),
		.scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .serial_port_enable(en), .port_mode_field(mode),
		.pin_direction_bit_scl(dir_scl), .pin_direction_bit_sda(dir_sda),
		.clock_release_set(crs), .irq_clear(irqc), .addr_wr(addr_wr),
		.addr_wdata(wdata), .buf_wr(buf_wr), .buf_wdata(wdata),
		.serial_port_irq_flag(irq), .address_update_flag(upd), .clock_release_bit(rel),
		.start_seen(ss), .stop_seen(ps), .read_not_write(rnw), .slave_address_reg(sar),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
	// ****************************************************
	// tasks
	// ****************************************************
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic w(input int c);
		repeat (c) @(negedge clock);
	endtask
	// one-cycle strobe: irq clear, release, buffer, address
	task automatic sw(input logic [3:0] k, input logic [7:0] d);
		@(negedge clock);
		{irqc, crs, buf_wr, addr_wr} = k;
		wdata = d;
		@(negedge clock);
		{irqc, crs, buf_wr, addr_wr} = 4'h0;
		w(2);
	endtask
	// head of receive fifo, then pop
	task automatic rx(input logic [7:0] e);
		w(40);
		chk({rx_valid, rx_data}, {1'b1, e});
		rx_ready = 1'b1;
		@(negedge clock);
		rx_ready = 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			stop_test();
		end
	end
	// ****************************************************
	// test sequence
	// ****************************************************
	initial begin
		{resetn, en, crs, irqc, addr_wr, buf_wr, rx_ready} = 7'h0;
		{dir_scl, dir_sda} = 2'b11;
		mode = MODE_SLV7_SP;
		wdata = 8'h00;
		w(20);
		resetn = 1'b1;
		w(10);
		chk({irq, upd, rel, ss, ps, scl_oe, sda_oe, rx_valid}, 16'h0020);
		$display("test reset done");
		{dir_scl, dir_sda} = 2'b00;
		w(10);
		chk({scl_oe, sda_oe, scl_o, sda_o}, 16'h000C);
		dir_sda = 1'b1;
		w(5);
		dir_scl = 1'b1;
		w(10);
		$display("test pin drive done");
		en = 1'b1;
		sw(4'h1, 8'hA0);
		chk(sar, 16'h00A0);
		bm.start();
		w(20);
		chk({ss, ps, irq}, 16'h0005);
		sw(4'h8, 8'h00);
		chk(irq, 16'h0000);
		bm.put(8'hA0, ack);
		chk(ack, 16'h0001);
		w(1);
		dir_sda = 1'b0;
		bm.put(8'h3C, ack);
		chk({ack, bm.lost}, 16'h0001);
		w(1);
		dir_sda = 1'b1;
		w(40);
		chk({ss, ps}, 16'h0001);
		bm.start();
		bm.put(8'hA0, ack);
		chk(ack, 16'h0001);
		bm.put(8'h3C, ack);
		rx(8'h3C);
		sw(4'h8, 8'h00);
		bm.stop();
		w(60);
		chk({ss, ps, irq}, 16'h0003);
		$display("test write done");
		sw(4'h2, 8'hFF);
		bm.start();
		bm.put(8'hA1, ack);
		w(80);
		chk({ack, rel, scl_oe, rnw}, 16'h000B);
		sw(4'h4, 8'h00);
		bm.stop();
		w(20);
		chk({rel, ps}, 16'h0003);
		$display("test read stretch done");
		mode = MODE_SLV10_SP;
		sw(4'h1, 8'hF0);
		bm.start();
		sw(4'h8, 8'h00);
		bm.put(8'hF0, ack);
		w(40);
		chk({ack, upd, scl_oe, irq}, 16'h000F);
		sw(4'h1, 8'h5A);
		w(10);
		chk({upd, scl_oe}, 16'h0000);
		bm.put(8'h5A, ack);
		w(40);
		chk({ack, upd, scl_oe}, 16'h0007);
		sw(4'h1, 8'hF0);
		bm.put(8'h77, ack);
		rx(8'h77);
		bm.stop();
		w(20);
		$display("test ten bit done");
		en = 1'b0;
		w(20);
		chk({ss, ps}, 16'h0000);
		$display("test disable done");
		stop_test();
	end
endmodule
`default_nettype wire
